// File: logic/dcs_pkg.sv
// Constants and types shared by both ends of the DDR3 command link.
// Assumes one 250 MHz clock for both ends and one data beat per clock.
package dcs_pkg;
   localparam int CLK_PS = 4000;
   localparam int CL = 5;
   localparam int AL = 0;
   localparam int CWL = 5;
   localparam int RL = CL + AL;
   localparam int WL = CWL + AL;
   localparam int ANPD_CYC = WL - 1;
   localparam int REFI_NS = 7800;
   localparam int REFI_CYC = REFI_NS * 1000 / CLK_PS;
   localparam int RFC_NS = 260;
   localparam int RFC_CYC = (RFC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RCD_PS = 13750;
   localparam int RCD_CYC = (RCD_PS + CLK_PS - 1) / CLK_PS;
   localparam int RP_PS = 13750;
   localparam int RP_CYC = (RP_PS + CLK_PS - 1) / CLK_PS;
   localparam int MOD_CYC = 12;
   localparam int ZQINIT_CYC = 512;
   localparam int WTR_CYC = 4;
   localparam int RTW_EXTRA = 2;
   localparam int RST_HOLD_NS = 200000;
   localparam int RST_HOLD_CYC = RST_HOLD_NS * 1000 / CLK_PS;
   localparam int MAX_POSTPONE = 8;
   localparam int DQ_W = 16;
   localparam int ADDR_W = 16;
   localparam int BANK_W = 3;
   localparam int COL_W = 6;
   localparam int BL_LSB = 0;
   localparam int CHOP_BIT = 12;
   localparam int AP_BIT = 10;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [1:0] BL_RESET = BL_FIXED8;
   localparam logic [3:0] BEATS8 = 4'h8;
   localparam logic [3:0] BEATS4 = 4'h4;

   typedef enum logic [2:0] {
      CMD_NOP = 3'b000,
      CMD_MRS = 3'b001,
      CMD_REF = 3'b010,
      CMD_PRE = 3'b011,
      CMD_ACT = 3'b100,
      CMD_WR = 3'b101,
      CMD_RD = 3'b110,
      CMD_ZQCL = 3'b111
   } dcs_cmd_t;

   // Field value 11 is reserved and treated as the eight-beat burst
   function automatic logic dcs_is_chop(input logic [1:0] field, input logic chop_bit);
      dcs_is_chop = (field == BL_FIXED4) || ((field == BL_OTF) && !chop_bit);
   endfunction
endpackage

// File: logic/dcs_link_if.sv
// Command, address and data link between controller and DRAM.
// Assumes both ends share clk_sys; the shared data wires are resolved here.
`timescale 1ns/1ns
interface dcs_link_if (
   input wire logic clk_sys
);
   import dcs_pkg::*;
   logic reset_n;
   logic cke;
   logic cs_n;
   dcs_cmd_t cmd;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic odt;
   logic [DQ_W-1:0] dq_c;
   logic dq_c_oe_n;
   logic [DQ_W-1:0] dq_d;
   logic dq_d_oe_n;
   logic dqs_c;
   logic dqs_c_oe_n;
   logic dqs_d;
   logic dqs_d_oe_n;
   logic [DQ_W-1:0] dq;
   logic dqs;

   // An undriven bus reads as zero, like a weak pull-down
   assign dq = !dq_c_oe_n ? dq_c : (!dq_d_oe_n ? dq_d : '0);
   assign dqs = !dqs_c_oe_n ? dqs_c : (!dqs_d_oe_n ? dqs_d : 1'b0);

   modport ctl (
      output reset_n, cke, cs_n, cmd, bank, addr, odt,
      output dq_c, dq_c_oe_n, dqs_c, dqs_c_oe_n,
      input dq, dqs
   );
   modport dram (
      input reset_n, cke, cs_n, cmd, bank, addr, odt,
      output dq_d, dq_d_oe_n, dqs_d, dqs_d_oe_n,
      input dq, dqs
   );
endinterface

// File: logic/dcs_dram.sv
// DRAM end of the link: mode register, bank state, read and write bursts.
// Assumes the controller keeps the command spacing; supply_low_v comes from
// logic on clk_sys, so it is not synchronised.
`timescale 1ns/1ns
module dcs_dram (
   input wire logic clk_sys,
   input wire logic sys_rst,
   dcs_link_if.dram link,
   input wire logic supply_low_v,
   output logic supply_mode,
   output logic powered_down,
   output logic odt_async,
   output logic term_on
);
   import dcs_pkg::*;
   logic [1:0] burst_length_field;
   logic [7:0] open_banks;
   logic [RL-1:0] rd_v_sr;
   logic [RL-1:0] rd_c_sr;
   logic [COL_W-1:0] rd_col_sr [RL];
   logic [WL-1:0] wr_v_sr;
   logic [WL-1:0] wr_c_sr;
   logic [COL_W-1:0] wr_col_sr [WL];
   logic [DQ_W-1:0] mem [2**COL_W];
   logic [3:0] rd_left;
   logic [COL_W-1:0] rd_ptr;
   logic [3:0] wr_left;
   logic [COL_W-1:0] wr_ptr;
   logic rst_seen_n;
   logic cke_q;
   logic [3:0] odt_cnt;
   logic [3:0] next_odt_cnt;
   logic cmd_ok;
   logic is_rd;
   logic is_wr;
   logic cmd_chop;

   assign cmd_ok = link.reset_n && link.cke && !link.cs_n;
   assign is_rd = cmd_ok && link.cmd == CMD_RD;
   assign is_wr = cmd_ok && link.cmd == CMD_WR;
   assign cmd_chop = dcs_is_chop(burst_length_field, link.addr[CHOP_BIT]);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         burst_length_field <= BL_RESET;
         open_banks <= 8'h00;
      end else if (!link.reset_n) begin
         burst_length_field <= BL_RESET;
         open_banks <= 8'h00;
      end else if (cmd_ok) begin
         case (link.cmd)
            CMD_MRS: begin
               if (link.bank == 3'h0) begin
                  burst_length_field <= link.addr[BL_LSB +: 2];
               end
            end
            CMD_ACT: open_banks[link.bank] <= 1'b1;
            CMD_PRE: begin
               if (link.addr[AP_BIT]) begin
                  open_banks <= 8'h00;
               end else begin
                  open_banks[link.bank] <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // Command pipelines; the chop choice is frozen per command
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_v_sr <= '0;
         rd_c_sr <= '0;
         wr_v_sr <= '0;
         wr_c_sr <= '0;
         for (int i = 0; i < RL; i++) rd_col_sr[i] <= '0;
         for (int i = 0; i < WL; i++) wr_col_sr[i] <= '0;
      end else begin
         rd_v_sr <= {rd_v_sr[RL-2:0], is_rd};
         rd_c_sr <= {rd_c_sr[RL-2:0], cmd_chop};
         wr_v_sr <= {wr_v_sr[WL-2:0], is_wr};
         wr_c_sr <= {wr_c_sr[WL-2:0], cmd_chop};
         rd_col_sr[0] <= link.addr[COL_W-1:0];
         wr_col_sr[0] <= link.addr[COL_W-1:0];
         for (int i = 1; i < RL; i++) rd_col_sr[i] <= rd_col_sr[i-1];
         for (int i = 1; i < WL; i++) wr_col_sr[i] <= wr_col_sr[i-1];
      end
   end

   // First beat appears read_latency cycles after the READ, strobe with it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_left <= 4'h0;
         rd_ptr <= '0;
         link.dq_d <= '0;
         link.dq_d_oe_n <= 1'b1;
         link.dqs_d <= 1'b0;
         link.dqs_d_oe_n <= 1'b1;
      end else if (rd_v_sr[RL-2]) begin
         rd_left <= (rd_c_sr[RL-2] ? BEATS4 : BEATS8) - 4'h1;
         rd_ptr <= rd_col_sr[RL-2] + 1'b1;
         link.dq_d <= mem[rd_col_sr[RL-2]];
         link.dq_d_oe_n <= 1'b0;
         link.dqs_d <= 1'b1;
         link.dqs_d_oe_n <= 1'b0;
      end else if (rd_left != 4'h0) begin
         rd_left <= rd_left - 4'h1;
         rd_ptr <= rd_ptr + 1'b1;
         link.dq_d <= mem[rd_ptr];
         link.dqs_d <= !link.dqs_d;
      end else begin
         link.dq_d_oe_n <= 1'b1;
         link.dqs_d <= 1'b0;
         link.dqs_d_oe_n <= 1'b1;
      end
   end

   // Write beats are taken write_latency cycles after the WRITE
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_left <= 4'h0;
         wr_ptr <= '0;
      end else if (wr_v_sr[WL-1]) begin
         wr_left <= (wr_c_sr[WL-1] ? BEATS4 : BEATS8) - 4'h1;
         wr_ptr <= wr_col_sr[WL-1] + 1'b1;
      end else if (wr_left != 4'h0) begin
         wr_left <= wr_left - 4'h1;
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // Array has no reset; contents are undefined until written
   always_ff @(posedge clk_sys) begin
      if (wr_v_sr[WL-1]) begin
         mem[wr_col_sr[WL-1]] <= link.dq;
      end else if (wr_left != 4'h0) begin
         mem[wr_ptr] <= link.dq;
      end
   end

   always_comb begin
      next_odt_cnt = odt_cnt;
      if (link.cke != cke_q) begin
         next_odt_cnt = 4'(ANPD_CYC);
      end else if (odt_cnt != 4'h0) begin
         next_odt_cnt = odt_cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cke_q <= 1'b0;
         odt_cnt <= 4'h0;
         odt_async <= 1'b0;
         powered_down <= 1'b0;
         term_on <= 1'b0;
      end else begin
         cke_q <= link.cke;
         odt_cnt <= next_odt_cnt;
         odt_async <= next_odt_cnt != 4'h0;
         powered_down <= link.reset_n && !link.cke;
         term_on <= link.odt;
      end
   end

   // Supply mode is caught only as reset is released
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rst_seen_n <= 1'b0;
         supply_mode <= 1'b0;
      end else begin
         rst_seen_n <= link.reset_n;
         if (!rst_seen_n && link.reset_n) begin
            supply_mode <= supply_low_v;
         end
      end
   end
endmodule

// File: logic/dcs_ctrl.sv
// Controller end of the link with its request FIFO.
// Assumes requests come from logic on clk_sys; one open row in bank 0.
`timescale 1ns/1ns
module dcs_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;

   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
         if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule

module dcs_ctrl #(
   parameter int RESET_HOLD = dcs_pkg::RST_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   dcs_link_if.ctl link,
   input wire logic [1:0] burst_sel,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_chop,
   input wire logic [dcs_pkg::COL_W-1:0] req_col,
   input wire logic [dcs_pkg::DQ_W-1:0] req_wdata,
   input wire logic pd_req,
   input wire logic supply_switch,
   output logic supply_low_v,
   output logic rd_valid,
   output logic [dcs_pkg::DQ_W-1:0] rd_data,
   output logic ready
);
   import dcs_pkg::*;
   localparam int FW = 2 + COL_W + DQ_W;
   typedef enum logic [3:0] {
      ST_RST = 4'h0,
      ST_MRS = 4'h1,
      ST_ZQCL = 4'h2,
      ST_ACT = 4'h3,
      ST_IDLE = 4'h4,
      ST_PRE = 4'h5,
      ST_REF = 4'h6,
      ST_PDOWN = 4'h7,
      ST_WAIT = 4'h8
   } dcs_state_t;
   dcs_state_t state;
   dcs_state_t ret;
   logic [15:0] wait_cnt;
   logic [1:0] field;
   logic f_valid;
   logic [FW-1:0] f_data;
   logic f_write;
   logic f_chop_req;
   logic f_chop;
   logic [3:0] f_beats;
   logic [4:0] gap_rd;
   logic [4:0] gap_wr;
   logic [WL-1:0] wr_v_sr;
   logic [WL-1:0] wr_c_sr;
   logic [DQ_W-1:0] wr_d_sr [WL];
   // One stage longer than the read latency: the returning beat is sampled a cycle after it is launched
   logic [RL:0] rd_v_sr;
   logic [RL:0] rd_c_sr;
   logic [3:0] wb_left;
   logic [3:0] cap_left;
   logic [10:0] refi_cnt;
   logic [3:0] ref_pending;
   logic ref_tick;
   logic ref_force;
   logic sw_pend;
   logic quiet;
   logic take;
   logic ref_go;
   logic sw_go;

   dcs_fifo #(.WIDTH(FW), .DEPTH(16)) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data({req_write, req_chop, req_col, req_wdata}),
      .out_valid(f_valid),
      .out_ready(take),
      .out_data(f_data)
   );

   assign f_write = f_data[FW-1];
   assign f_chop_req = f_data[FW-2];
   assign f_chop = dcs_is_chop(field, !f_chop_req);
   assign f_beats = f_chop ? BEATS4 : BEATS8;
   assign quiet = wr_v_sr == '0 && rd_v_sr == '0 && wb_left == 4'h0 && cap_left == 4'h0
      && gap_rd == 5'h0 && gap_wr == 5'h0;
   assign ref_force = ref_pending >= 4'(MAX_POSTPONE);
   assign sw_go = state == ST_IDLE && sw_pend && quiet;
   assign ref_go = state == ST_IDLE && !sw_pend && quiet && (ref_force || (ref_pending != 4'h0 && !f_valid));
   assign take = state == ST_IDLE && !sw_pend && !ref_force && f_valid
      && (f_write ? gap_wr == 5'h0 : gap_rd == 5'h0);
   assign ready = state == ST_IDLE;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_RST;
         ret <= ST_RST;
         wait_cnt <= 16'(RESET_HOLD);
         field <= BL_RESET;
         supply_low_v <= 1'b0;
         link.reset_n <= 1'b0;
         link.cke <= 1'b0;
         link.cs_n <= 1'b1;
         link.cmd <= CMD_NOP;
         link.bank <= '0;
         link.addr <= '0;
      end else begin
         link.cs_n <= 1'b1;
         link.cmd <= CMD_NOP;
         case (state)
            ST_RST: begin
               link.reset_n <= 1'b0;
               link.cke <= 1'b0;
               if (wait_cnt == 16'h0) begin
                  link.reset_n <= 1'b1;
                  link.cke <= 1'b1;
                  state <= ST_MRS;
               end else begin
                  wait_cnt <= wait_cnt - 16'h1;
               end
            end
            ST_MRS: begin
               field <= burst_sel;
               link.cs_n <= 1'b0;
               link.cmd <= CMD_MRS;
               link.bank <= '0;
               link.addr <= {14'h0000, burst_sel};
               wait_cnt <= 16'(MOD_CYC - 1);
               ret <= ST_ZQCL;
               state <= ST_WAIT;
            end
            ST_ZQCL: begin
               link.cs_n <= 1'b0;
               link.cmd <= CMD_ZQCL;
               wait_cnt <= 16'(ZQINIT_CYC - 1);
               ret <= ST_ACT;
               state <= ST_WAIT;
            end
            ST_ACT: begin
               link.cs_n <= 1'b0;
               link.cmd <= CMD_ACT;
               link.bank <= '0;
               link.addr <= '0;
               wait_cnt <= 16'(RCD_CYC - 1);
               ret <= ST_IDLE;
               state <= ST_WAIT;
            end
            ST_IDLE: begin
               if (sw_go) begin
                  // Reset drops on the same edge as the supply select flips
                  supply_low_v <= !supply_low_v;
                  link.reset_n <= 1'b0;
                  link.cke <= 1'b0;
                  wait_cnt <= 16'(RESET_HOLD);
                  state <= ST_RST;
               end else if (ref_go) begin
                  state <= ST_PRE;
               end else if (take) begin
                  link.cs_n <= 1'b0;
                  link.cmd <= f_write ? CMD_WR : CMD_RD;
                  link.bank <= '0;
                  link.addr <= '0;
                  link.addr[COL_W-1:0] <= f_data[DQ_W +: COL_W];
                  link.addr[CHOP_BIT] <= !f_chop_req;
               end else if (pd_req && quiet) begin
                  // Previous edge carried a NOP and bank 0 stays open
                  link.cke <= 1'b0;
                  state <= ST_PDOWN;
               end
            end
            ST_PRE: begin
               link.cs_n <= 1'b0;
               link.cmd <= CMD_PRE;
               link.addr <= '0;
               link.addr[AP_BIT] <= 1'b1;
               wait_cnt <= 16'(RP_CYC - 1);
               ret <= ST_REF;
               state <= ST_WAIT;
            end
            ST_REF: begin
               link.cs_n <= 1'b0;
               link.cmd <= CMD_REF;
               wait_cnt <= 16'(RFC_CYC - 1);
               ret <= ST_ACT;
               state <= ST_WAIT;
            end
            ST_PDOWN: begin
               if (!pd_req || f_valid || ref_pending != 4'h0 || sw_pend) begin
                  link.cke <= 1'b1;
                  wait_cnt <= 16'(ANPD_CYC - 1);
                  ret <= ST_IDLE;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Only NOPs go out while waiting
               if (wait_cnt == 16'h0) begin
                  state <= ret;
               end else begin
                  wait_cnt <= wait_cnt - 16'h1;
               end
            end
            default: state <= ST_RST;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sw_pend <= 1'b0;
      end else if (supply_switch) begin
         sw_pend <= 1'b1;
      end else if (sw_go) begin
         sw_pend <= 1'b0;
      end
   end

   // Tick and refresh in one cycle cancel, so no tick is lost
   assign ref_tick = refi_cnt == 11'(REFI_CYC - 1);
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         refi_cnt <= 11'h000;
         ref_pending <= 4'h0;
      end else if (state == ST_RST) begin
         refi_cnt <= 11'h000;
         ref_pending <= 4'h0;
      end else begin
         refi_cnt <= ref_tick ? 11'h000 : refi_cnt + 11'h001;
         ref_pending <= ref_pending + {3'h0, ref_tick} - {3'h0, state == ST_REF};
      end
   end

   // Gaps are one beat per clock, never below the column delay
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gap_rd <= 5'h00;
         gap_wr <= 5'h00;
      end else if (take && f_write) begin
         gap_wr <= 5'(f_beats - 4'h1);
         gap_rd <= 5'(WL + WTR_CYC - 1) + 5'(f_beats);
      end else if (take) begin
         gap_rd <= 5'(f_beats - 4'h1);
         gap_wr <= 5'(RL + RTW_EXTRA - WL - 1) + 5'(f_beats);
      end else begin
         if (gap_rd != 5'h00) gap_rd <= gap_rd - 5'h01;
         if (gap_wr != 5'h00) gap_wr <= gap_wr - 5'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_v_sr <= '0;
         wr_c_sr <= '0;
         rd_v_sr <= '0;
         rd_c_sr <= '0;
         for (int i = 0; i < WL; i++) wr_d_sr[i] <= '0;
      end else begin
         wr_v_sr <= {wr_v_sr[WL-2:0], take && f_write};
         wr_c_sr <= {wr_c_sr[WL-2:0], f_chop};
         rd_v_sr <= {rd_v_sr[RL-1:0], take && !f_write};
         rd_c_sr <= {rd_c_sr[RL-1:0], f_chop};
         wr_d_sr[0] <= f_data[DQ_W-1:0];
         for (int i = 1; i < WL; i++) wr_d_sr[i] <= wr_d_sr[i-1];
      end
   end

   // Write beats from the request word, one higher per beat
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wb_left <= 4'h0;
         link.dq_c <= '0;
         link.dq_c_oe_n <= 1'b1;
         link.dqs_c <= 1'b0;
         link.dqs_c_oe_n <= 1'b1;
         link.odt <= 1'b0;
      end else begin
         link.odt <= wr_v_sr != '0 || wb_left != 4'h0;
         if (wr_v_sr[WL-1]) begin
            wb_left <= (wr_c_sr[WL-1] ? BEATS4 : BEATS8) - 4'h1;
            link.dq_c <= wr_d_sr[WL-1];
            link.dq_c_oe_n <= 1'b0;
            link.dqs_c <= 1'b1;
            link.dqs_c_oe_n <= 1'b0;
         end else if (wb_left != 4'h0) begin
            wb_left <= wb_left - 4'h1;
            link.dq_c <= link.dq_c + 1'b1;
            link.dqs_c <= !link.dqs_c;
         end else begin
            link.dq_c_oe_n <= 1'b1;
            link.dqs_c <= 1'b0;
            link.dqs_c_oe_n <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cap_left <= 4'h0;
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else if (rd_v_sr[RL]) begin
         cap_left <= (rd_c_sr[RL] ? BEATS4 : BEATS8) - 4'h1;
         rd_valid <= 1'b1;
         rd_data <= link.dq;
      end else if (cap_left != 4'h0) begin
         cap_left <= cap_left - 4'h1;
         rd_valid <= 1'b1;
         rd_data <= link.dq;
      end else begin
         rd_valid <= 1'b0;
      end
   end
endmodule

// File: sim/dcs_asserts.sv
// Assertions on the command and data link between controller and DRAM.
// Assumes one clock; sees only the link wires and sys_rst.
`timescale 1ns/1ns
module dcs_asserts (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reset_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire dcs_pkg::dcs_cmd_t cmd,
   input wire logic [dcs_pkg::ADDR_W-1:0] addr,
   input wire logic dq_c_oe_n,
   input wire logic dq_d_oe_n
);
   import dcs_pkg::*;
   logic [1:0] field;
   logic [6:0] ref_age;
   int gap;
   wire logic iss = reset_n && cke && !cs_n;
   wire logic nop_s = cs_n || cmd == CMD_NOP;
   wire logic rd_now = iss && cmd == CMD_RD;
   wire logic wr_now = iss && cmd == CMD_WR;
   wire logic chop = field == BL_FIXED4 || (field == BL_OTF && !addr[CHOP_BIT]);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Burst field as the DRAM holds it; lost while the DRAM sits in reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         field <= BL_RESET;
      end else if (!reset_n) begin
         field <= BL_RESET;
      end else if (iss && cmd == CMD_MRS) begin
         field <= addr[1:0];
      end
   end
   // Age since refresh stops one short of the full time: a command on that edge is legal
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ref_age <= 7'h0;
         gap <= 0;
      end else begin
         ref_age <= (iss && cmd == CMD_REF) ? 7'h1 : (ref_age != 0 && ref_age < RFC_CYC - 1) ? ref_age + 7'h1 : 7'h0;
         gap <= (!reset_n || (iss && cmd == CMD_REF)) ? 0 : gap + 1;
      end
   end
   refresh_idle_a: assert property (ref_age != 0 |-> nop_s) else $error("command during refresh");
   refresh_gap_a: assert property (gap <= 9 * REFI_CYC) else $error("refresh gap too long");
   mrs_zq_gap_a: assert property (iss && cmd == CMD_MRS |=> nop_s [*8] ##1 nop_s [*4] ##1 (iss && cmd == CMD_ZQCL))
      else $error("mode set gap broken");
   rd_eight_a: assert property (rd_now && !chop |-> ##5 (!dq_d_oe_n) [*8]) else $error("short read burst");
   rd_chop_a: assert property (rd_now && chop |-> ##5 (!dq_d_oe_n) [*4] ##1 (dq_d_oe_n || $past(rd_now, 5)))
      else $error("chopped read wrong length");
   wr_eight_a: assert property (wr_now && !chop |-> ##5 (!dq_c_oe_n) [*8]) else $error("short write burst");
   pd_entry_a: assert property (reset_n && $fell(cke) |-> $past(nop_s)) else $error("power-down after command");
   bus_turn_a: assert property (dq_c_oe_n || dq_d_oe_n) else $error("both ends drive data");
   cover property (rd_now && chop);
   cover property (wr_now && !chop);
   cover property (reset_n && $fell(cke));
endmodule

// File: sim/ddr3_command_sequencing_test.sv
// Self-checking bench: controller and DRAM joined by the link interface.
// Assumes the reset hold is shortened to 20 cycles.
`timescale 1ns/1ns
module ddr3_command_sequencing_test;
   import dcs_pkg::*;
   logic clk_sys, sys_rst, req_valid, req_ready, req_write, req_chop, pd_req, supply_switch;
   logic supply_low_v, rd_valid, ready, supply_mode, powered_down, odt_async, term_on;
   logic [1:0] burst_sel;
   logic [5:0] req_col;
   logic [15:0] req_wdata, rd_data;
   int fails = 0;
   int compares = 0;
   dcs_link_if i_dcs_link_if (.clk_sys(clk_sys));
   wire logic [4:0] watch = {req_ready, i_dcs_link_if.reset_n, i_dcs_link_if.cke, rd_valid, ready};
   dcs_ctrl #(.RESET_HOLD(20)) i_dcs_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_dcs_link_if),
      .burst_sel(burst_sel), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_chop(req_chop), .req_col(req_col), .req_wdata(req_wdata), .pd_req(pd_req),
      .supply_switch(supply_switch), .supply_low_v(supply_low_v), .rd_valid(rd_valid),
      .rd_data(rd_data), .ready(ready));
   dcs_dram i_dcs_dram (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_dcs_link_if),
      .supply_low_v(supply_low_v), .supply_mode(supply_mode), .powered_down(powered_down),
      .odt_async(odt_async), .term_on(term_on));
   dcs_asserts i_dcs_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_n(i_dcs_link_if.reset_n),
      .cke(i_dcs_link_if.cke), .cs_n(i_dcs_link_if.cs_n), .cmd(i_dcs_link_if.cmd),
      .addr(i_dcs_link_if.addr), .dq_c_oe_n(i_dcs_link_if.dq_c_oe_n), .dq_d_oe_n(i_dcs_link_if.dq_d_oe_n));
   task automatic summarize();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_for(input int b, input logic v);
      int k;
      for (k = 0; k < 20000 && watch[b] !== v; k++) begin
         @(negedge clk_sys);
      end
      if (watch[b] !== v) begin
         fails++;
         summarize();
      end
   endtask
   task automatic push(input logic w, input logic c, input logic [5:0] col, input logic [15:0] d);
      wait_for(4, 1'b1);
      req_valid = 1'b1;
      req_write = w;
      req_chop = c;
      req_col = col;
      req_wdata = d;
      @(negedge clk_sys);
      req_valid = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic get(input int n, input logic [15:0] base);
      int i;
      for (i = 0; i < n; i++) begin
         wait_for(1, 1'b1);
         check(rd_data, base + 16'(i));
         @(negedge clk_sys);
      end
   endtask
   // Counts odt_async over a window that holds one transition period
   task automatic odt_window();
      int k, hi;
      hi = 0;
      for (k = 0; k < 10; k++) begin
         hi += (odt_async === 1'b1);
         @(negedge clk_sys);
      end
      check(16'(hi), 16'(ANPD_CYC));
   endtask
   task automatic t_otf();
      push(1'b1, 1'b1, 6'h00, 16'h1000);
      push(1'b1, 1'b0, 6'h08, 16'h2000);
      push(1'b0, 1'b1, 6'h00, 16'h0);
      push(1'b0, 1'b0, 6'h08, 16'h0);
      get(4, 16'h1000);
      get(8, 16'h2000);
   endtask
   // A queued request wakes the DRAM, so requests are pushed only after exit and drain in order
   task automatic t_pd();
      int k;
      pd_req = 1'b1;
      wait_for(2, 1'b0);
      odt_window();
      check(16'(powered_down), 16'h1);
      pd_req = 1'b0;
      wait_for(2, 1'b1);
      odt_window();
      check(16'(powered_down), 16'h0);
      for (k = 0; k < 16; k++) begin
         push(1'b1, 1'b1, 6'h28, 16'h4000 + 16'(k * 16));
      end
      check(16'(req_ready), 16'h1);
      push(1'b0, 1'b1, 6'h28, 16'h0);
      get(4, 16'h40f0);
   endtask
   task automatic t_modes();
      logic [1:0] f [3] = '{2'h2, 2'h0, 2'h3};
      int m;
      for (m = 0; m < 3; m++) begin
         burst_sel = f[m];
         supply_switch = 1'b1;
         @(negedge clk_sys);
         supply_switch = 1'b0;
         wait_for(3, 1'b0);
         wait_for(0, 1'b1);
         check(16'(supply_mode), 16'((m + 1) % 2));
         push(1'b1, 1'b0, 6'h10, 16'h3000);
         push(1'b0, 1'b1, 6'h10, 16'h0);
         get(f[m] == BL_FIXED4 ? 4 : 8, 16'h3000);
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      int k;
      sys_rst = 1'b1;
      burst_sel = BL_OTF;
      {req_valid, req_write, req_chop, pd_req, supply_switch} = 5'h0;
      req_col = 6'h0;
      req_wdata = 16'h0;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      wait_for(0, 1'b1);
      check(16'(supply_mode), 16'h0);
      t_otf();
      t_pd();
      for (k = 0; k < 9 * REFI_CYC && !(i_dcs_link_if.cmd === CMD_REF && i_dcs_link_if.cs_n === 1'b0); k++) begin
         @(negedge clk_sys);
      end
      check(16'(k < 9 * REFI_CYC), 16'h1);
      t_modes();
      summarize();
   end
endmodule
